// >>> clock_select_pkg.sv
// constants for the system clock select, divide and precise oscillator block
package clock_select_pkg;
  // ==========================================================================
  // register offsets
  localparam logic [7:0] SRC_DIV_ADDR  = 8'ha9;
  localparam logic [7:0] OSC_CTL_ADDR  = 8'hb2;
  localparam logic [7:0] OSC_TRIM_ADDR = 8'hb3;
  // ==========================================================================
  // reset values
  localparam logic [7:0] SRC_DIV_RESET = 8'h34;
  localparam logic [7:0] OSC_CTL_RESET = 8'h0f;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ==========================================================================
  // field positions
  localparam int APPLIED_BIT  = 7;
  localparam int DIV_HI       = 6;
  localparam int DIV_LO       = 4;
  localparam int UNUSED_BIT   = 3;
  localparam int SRC_HI       = 2;
  localparam int SRC_LO       = 0;
  localparam int OSC_ON_BIT   = 7;
  localparam int SETTLED_BIT  = 6;
  localparam int DITHER_BIT   = 7;
  localparam int TRIM_HI      = 6;
  localparam logic [5:0] OSC_CTL_RSVD = 6'h0f;
  // ==========================================================================
  // source codes, index into the oscillator level vector
  localparam logic [2:0] SRC_PRECISE = 3'h0;
  localparam logic [2:0] SRC_EXT     = 3'h1;
  localparam logic [2:0] SRC_RSVD    = 3'h2;
  localparam logic [2:0] SRC_RTC     = 3'h3;
  localparam int OSC_PRECISE = 0;
  localparam int OSC_EXT     = 1;
  localparam int OSC_RTC     = 2;
  localparam int OSC_LP      = 3;
  // ==========================================================================
  // timing
  localparam int MAX_DIV_SRC_CYCLES = 128;
  localparam int SETTLE_CYCLES      = 16;
endpackage : clock_select_pkg

// >>> system_clock_select_divide.sv
// system clock source select, power-of-two divider and precise oscillator
// Operation
// - system clock is undivided source divided by two to the divide code
// - new divide ratio takes effect within 128 undivided source cycles
// - read-only applied flag: 0 while divide pending, 1 once applied
// - source may change while running, after one slower-oscillator period
// - source code: 0 precise, 1 external, 2 reserved, 3 rtc, 1xx low power
// - bit 3 of source/divide register reads zero; software writes zero
// - precise oscillator runs while control bit 7 is set
// - settled flag reads 1 only while oscillator runs at set frequency
// - low six control bits read 001111b; software writes 001111b
// - trim bit 7 turns on spread-spectrum dithering
// - seven-bit trim field steers oscillator, larger value is slower
// - factory trim loaded at reset; software keeps 16 to 24.5 MHz
`timescale 1ns/1ns
module system_clock_select_divide #(
  parameter int SETTLE = clock_select_pkg::SETTLE_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic [3:0] osc_level,
  input  wire logic [6:0] factory_trim,
  output logic            sysclk_out,
  output logic            precise_osc_on,
  output logic            dither_on,
  output logic      [6:0] precise_osc_trim
);
  // ==========================================================================
  // helpers
  function automatic logic [1:0] osc_index(input logic [2:0] code);
    if (code[2])
      return 2'(clock_select_pkg::OSC_LP);
    else if (code == clock_select_pkg::SRC_EXT)
      return 2'(clock_select_pkg::OSC_EXT);
    else if (code == clock_select_pkg::SRC_RTC)
      return 2'(clock_select_pkg::OSC_RTC);
    else
      return 2'(clock_select_pkg::OSC_PRECISE);
  endfunction : osc_index

  function automatic logic src_valid(input logic [2:0] code);
    return code != clock_select_pkg::SRC_RSVD;
  endfunction : src_valid

  // ==========================================================================
  // registers
  logic [2:0] sysclk_divide_code;
  logic [2:0] sysclk_source_code;
  logic       divide_applied_flag;
  logic       precise_osc_settled;
  logic [2:0] active_div;
  logic [2:0] active_src;
  logic [3:0] osc_q;
  logic [6:0] half_cnt;
  logic       seen_old;
  logic       seen_new;
  logic [7:0] settle_cnt;

  logic wr_src_div;
  logic wr_ctl;
  logic wr_trim;
  assign wr_src_div = clk_en && sfr_wr &&
                      sfr_addr == clock_select_pkg::SRC_DIV_ADDR;
  assign wr_ctl     = clk_en && sfr_wr &&
                      sfr_addr == clock_select_pkg::OSC_CTL_ADDR;
  assign wr_trim    = clk_en && sfr_wr &&
                      sfr_addr == clock_select_pkg::OSC_TRIM_ADDR;

  logic div_change;
  assign div_change = wr_src_div &&
    sfr_wdata[clock_select_pkg::DIV_HI:clock_select_pkg::DIV_LO] !=
    sysclk_divide_code;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      sysclk_divide_code <= clock_select_pkg::SRC_DIV_RESET[6:4];
      sysclk_source_code <= clock_select_pkg::SRC_DIV_RESET[2:0];
    end else if (wr_src_div) begin
      // the unused bit is simply not stored, so it always reads zero
      sysclk_divide_code <=
        sfr_wdata[clock_select_pkg::DIV_HI:clock_select_pkg::DIV_LO];
      sysclk_source_code <=
        sfr_wdata[clock_select_pkg::SRC_HI:clock_select_pkg::SRC_LO];
    end
  end

  // factory trim is a level caught by the clocked reset branch
  always_ff @(posedge core_clk) begin
    if (reset) begin
      precise_osc_on   <= clock_select_pkg::OSC_CTL_RESET[7];
      dither_on        <= 1'b0;
      precise_osc_trim <= factory_trim;
    end else begin
      if (wr_ctl)
        precise_osc_on <= sfr_wdata[clock_select_pkg::OSC_ON_BIT];
      if (wr_trim) begin
        dither_on        <= sfr_wdata[clock_select_pkg::DITHER_BIT];
        precise_osc_trim <= sfr_wdata[clock_select_pkg::TRIM_HI:0];
      end
    end
  end

  // ==========================================================================
  // settle timer: a retrim or a switch-off drops the settled flag
  always_ff @(posedge core_clk) begin
    if (reset) begin
      settle_cnt          <= 8'h00;
      precise_osc_settled <= 1'b0;
    end else if (clk_en) begin
      if (!precise_osc_on || wr_trim || (wr_ctl &&
          !sfr_wdata[clock_select_pkg::OSC_ON_BIT])) begin
        settle_cnt          <= 8'h00;
        precise_osc_settled <= 1'b0;
      end else if (settle_cnt < 8'(SETTLE - 1)) begin
        settle_cnt <= settle_cnt + 8'h01;
      end else begin
        precise_osc_settled <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // source switch: wait for a rising edge of both old and new oscillator
  logic [3:0] osc_rise;
  logic       sel_level;
  logic       sel_edge;
  logic       div_done;
  logic       switch_now;
  assign osc_rise  = osc_level & ~osc_q;
  assign sel_level = src_valid(active_src) && osc_level[osc_index(active_src)];
  assign sel_edge  = src_valid(active_src) &&
                     (osc_level[osc_index(active_src)] !=
                      osc_q[osc_index(active_src)]);
  assign switch_now = (active_src != sysclk_source_code) &&
                      (seen_old || osc_rise[osc_index(active_src)] ||
                       !src_valid(active_src)) &&
                      (seen_new || osc_rise[osc_index(sysclk_source_code)] ||
                       !src_valid(sysclk_source_code));
  assign div_done = sel_edge &&
                    half_cnt == 7'((1 << active_div) - 1);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // start from the pin levels so leaving reset shows no false edge
      osc_q      <= osc_level;
      active_src <= clock_select_pkg::SRC_DIV_RESET[2:0];
      seen_old   <= 1'b0;
      seen_new   <= 1'b0;
    end else if (clk_en) begin
      osc_q <= osc_level;
      if (switch_now || active_src == sysclk_source_code) begin
        seen_old <= 1'b0;
        seen_new <= 1'b0;
      end else begin
        seen_old <= seen_old || osc_rise[osc_index(active_src)];
        seen_new <= seen_new || osc_rise[osc_index(sysclk_source_code)];
      end
      if (switch_now)
        active_src <= sysclk_source_code;
    end
  end

  // ==========================================================================
  // divider: counts source half periods, toggles output every 2^div of them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      half_cnt   <= 7'h00;
      sysclk_out <= 1'b0;
      active_div <= clock_select_pkg::SRC_DIV_RESET[6:4];
    end else if (clk_en) begin
      if (switch_now) begin
        half_cnt   <= 7'h00;
        // a pending ratio starts with the new source, so the apply time
        // stays bounded in cycles of the source that really runs
        active_div <= sysclk_divide_code;
      end else if (div_done) begin
        half_cnt <= 7'h00;
        // divide by one follows the source level, so a switch that lands
        // mid-period cannot leave the output inverted
        if (active_div == 3'h0)
          sysclk_out <= sel_level;
        else
          sysclk_out <= ~sysclk_out;
        // apart from a source switch, adopt a new ratio only at the end of a whole output period,
        // so no pulse is shorter than one source half period
        if (sysclk_out)
          active_div <= sysclk_divide_code;
      end else if (sel_edge) begin
        half_cnt <= half_cnt + 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset)
      divide_applied_flag <= 1'b0;
    else if (clk_en) begin
      if (div_change)
        divide_applied_flag <= 1'b0;
      else if (active_div == sysclk_divide_code)
        divide_applied_flag <= 1'b1;
    end
  end

  // ==========================================================================
  // register read port
  always_ff @(posedge core_clk) begin
    if (reset)
      sfr_rdata <= clock_select_pkg::UNMAPPED_READ;
    else if (clk_en && sfr_rd) begin
      unique case (sfr_addr)
        clock_select_pkg::SRC_DIV_ADDR:
          sfr_rdata <= {divide_applied_flag, sysclk_divide_code, 1'b0,
                        sysclk_source_code};
        clock_select_pkg::OSC_CTL_ADDR:
          sfr_rdata <= {precise_osc_on, precise_osc_settled,
                        clock_select_pkg::OSC_CTL_RSVD};
        clock_select_pkg::OSC_TRIM_ADDR:
          sfr_rdata <= {dither_on, precise_osc_trim};
        default:
          sfr_rdata <= clock_select_pkg::UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================================
  // checks
  logic [8:0] pend_rises;
  always_ff @(posedge core_clk) begin
    if (reset || divide_applied_flag)
      pend_rises <= 9'h000;
    else if (clk_en && sel_edge && sel_level && pend_rises != 9'h1ff)
      pend_rises <= pend_rises + 9'h001;
  end

  property p_flag_clear;
    @(posedge core_clk) disable iff (reset)
      div_change |=> !divide_applied_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("applied flag not cleared by divide change");

  property p_apply_bound;
    @(posedge core_clk) disable iff (reset)
      pend_rises <= 9'(clock_select_pkg::MAX_DIV_SRC_CYCLES + 2);
  endproperty
  a_apply_bound: assert property (p_apply_bound)
    else $error("divide change took too many source cycles");

  property p_flag_meaning;
    @(posedge core_clk) disable iff (reset)
      divide_applied_flag && !$past(div_change) |->
        active_div == sysclk_divide_code;
  endproperty
  a_flag_meaning: assert property (p_flag_meaning)
    else $error("applied flag set while divide pending");

  property p_unused_zero;
    @(posedge core_clk) disable iff (reset)
      clk_en && sfr_rd && sfr_addr == clock_select_pkg::SRC_DIV_ADDR
        |=> sfr_rdata[clock_select_pkg::UNUSED_BIT] == 1'b0;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit read nonzero");

  property p_rsvd_read;
    @(posedge core_clk) disable iff (reset)
      clk_en && sfr_rd && sfr_addr == clock_select_pkg::OSC_CTL_ADDR
        |=> sfr_rdata[5:0] == clock_select_pkg::OSC_CTL_RSVD;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("control reserved bits read wrong");

  property p_settled_needs_on;
    @(posedge core_clk) disable iff (reset)
      precise_osc_settled |-> precise_osc_on && !$past(wr_trim);
  endproperty
  a_settled_needs_on: assert property (p_settled_needs_on)
    else $error("settled while oscillator off or retrimmed");

  property p_enable_write;
    @(posedge core_clk) disable iff (reset)
      wr_ctl |=> precise_osc_on == $past(sfr_wdata[7]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("oscillator enable did not follow write");

  property p_dither_write;
    @(posedge core_clk) disable iff (reset)
      wr_trim |=> dither_on == $past(sfr_wdata[7]) &&
                  precise_osc_trim == $past(sfr_wdata[6:0]);
  endproperty
  a_dither_write: assert property (p_dither_write)
    else $error("trim register did not follow write");

  property p_out_on_edge;
    @(posedge core_clk) disable iff (reset)
      $changed(sysclk_out) |-> $past(sel_edge) && $past(clk_en);
  endproperty
  a_out_on_edge: assert property (p_out_on_edge)
    else $error("system clock moved without a source edge");

  property p_switch_wait;
    @(posedge core_clk) disable iff (reset)
      $changed(active_src) |-> $past(active_src != sysclk_source_code);
  endproperty
  a_switch_wait: assert property (p_switch_wait)
    else $error("source changed without request");

  property p_div_one;
    @(posedge core_clk) disable iff (reset)
      clk_en && active_div == 3'h0 && sel_edge && !switch_now
        |=> sysclk_out == $past(sel_level);
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("divide by one does not follow source");
endmodule : system_clock_select_divide

// >>> system_clock_select_divide_tb_top.sv
// self-checking testbench for the system clock select and divide block
`timescale 1ns/1ns
module system_clock_select_divide_tb_top;
  // ==========================================================================
  // stimulus, observed outputs and bookkeeping
  logic       core_clk         = 1'b0;
  logic       reset            = 1'b1;
  logic       clk_en           = 1'b1;
  logic [7:0] sfr_addr         = 8'h00;
  logic       sfr_wr           = 1'b0;
  logic       sfr_rd           = 1'b0;
  logic [7:0] sfr_wdata        = 8'h00;
  logic [3:0] osc_level        = 4'h0;
  logic [6:0] factory_trim     = 7'h00;
  logic [7:0] sfr_rdata;
  logic       sysclk_out;
  logic       precise_osc_on;
  logic       dither_on;
  logic [6:0] precise_osc_trim;
  logic       rd_seen          = 1'b0;
  logic [7:0] exp_q[$];
  int         half[4]          = '{2, 3, 4, 5};
  int         cnt[4]           = '{0, 0, 0, 0};
  int         srcs[9]          = '{4, 0, 1, 3, 5, 6, 7, 4, 0};
  int         failures         = 0;
  int         n_tests          = 0;
  int         seed             = 32'h5a1a5f87;

  system_clock_select_divide #(.SETTLE(8)) u_dut (
    .core_clk         (core_clk),
    .reset            (reset),
    .clk_en           (clk_en),
    .sfr_addr         (sfr_addr),
    .sfr_wr           (sfr_wr),
    .sfr_rd           (sfr_rd),
    .sfr_wdata        (sfr_wdata),
    .sfr_rdata        (sfr_rdata),
    .osc_level        (osc_level),
    .factory_trim     (factory_trim),
    .sysclk_out       (sysclk_out),
    .precise_osc_on   (precise_osc_on),
    .dither_on        (dither_on),
    .precise_osc_trim (precise_osc_trim)
  );

  always #10 core_clk = ~core_clk;

  // ==========================================================================
  // oscillators: distinct half periods so a wrong source shows in the period;
  // the precise one stands still while the block keeps it switched off
  always @(negedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] = cnt[i] + 1;
      if (cnt[i] >= half[i]) begin
        cnt[i] = 0;
        osc_level[i] <= (i == 0) ? (~osc_level[i] & precise_osc_on)
                                 : ~osc_level[i];
      end
    end
  end

  // ==========================================================================
  // read monitor: oldest expected note against the registered read data
  always @(posedge core_clk) rd_seen <= sfr_rd & clk_en & ~reset;
  always @(negedge core_clk) begin
    if (rd_seen) check(16'(sfr_rdata), 16'(exp_q.pop_front()));
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge core_clk);
    sfr_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk);
    sfr_rd   = 1'b0;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle

  // period between two rising edges; a missing edge ends the run
  task automatic measure(output int p);
    logic prev;
    int   mark;
    mark = -1;
    p    = 0;
    prev = sysclk_out;
    for (int t = 0; t < 6000; t++) begin
      @(negedge core_clk);
      if (sysclk_out === 1'b1 && prev === 1'b0) begin
        if (mark >= 0) begin
          p = t - mark;
          return;
        end
        mark = t;
      end
      prev = sysclk_out;
    end
    failures++;
    report_and_stop();
  endtask : measure

  // ==========================================================================
  // main sequence
  initial begin
    int         p;
    int         ix;
    int         ch;
    logic [2:0] sc;
    logic [2:0] dv;
    logic [7:0] d;
    logic       lvl;
    factory_trim = 7'($random(seed));
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    idle(3);
    check({7'h00, precise_osc_on, dither_on, precise_osc_trim},
          {9'h000, factory_trim});
    rd(clock_select_pkg::SRC_DIV_ADDR, 8'hb4);
    rd(clock_select_pkg::OSC_CTL_ADDR, clock_select_pkg::OSC_CTL_RESET);
    rd(clock_select_pkg::OSC_TRIM_ADDR, {1'b0, factory_trim});
    rd(8'ha0, 8'h00);
    // enable: settled only after the settle count; read-only bits ignored
    wr(clock_select_pkg::OSC_CTL_ADDR, 8'h8f);
    check(16'(precise_osc_on), 16'h0001);
    rd(clock_select_pkg::OSC_CTL_ADDR, 8'h8f);
    idle(12);
    wr(clock_select_pkg::OSC_CTL_ADDR, 8'hcf);
    rd(clock_select_pkg::OSC_CTL_ADDR, 8'hcf);
    for (int k = 0; k < 3; k++) begin
      d = 8'($random(seed));
      wr(clock_select_pkg::OSC_TRIM_ADDR, d);
      check(16'({dither_on, precise_osc_trim}), 16'(d));
      rd(clock_select_pkg::OSC_CTL_ADDR, 8'h8f);
      rd(clock_select_pkg::OSC_TRIM_ADDR, d);
      idle(12);
      rd(clock_select_pkg::OSC_CTL_ADDR, 8'hcf);
    end
    // a write while the clock enable is low must be lost
    @(negedge core_clk);
    clk_en = 1'b0;
    wr(clock_select_pkg::OSC_TRIM_ADDR, ~d);
    clk_en = 1'b1;
    rd(clock_select_pkg::OSC_TRIM_ADDR, d);
    wr(clock_select_pkg::OSC_CTL_ADDR, 8'h0f);
    check(16'(precise_osc_on), 16'h0000);
    rd(clock_select_pkg::OSC_CTL_ADDR, 8'h0f);
    wr(clock_select_pkg::OSC_CTL_ADDR, 8'h8f);
    // flash timing control sits outside this block and is left alone
    // every divide code and every source decode, switched on the fly
    for (int k = 0; k < 9; k++) begin
      sc = 3'(srcs[k]);
      dv = 3'(k);
      ix = sc[2] ? 3 : ((sc == 3'h3) ? 2 : int'(sc));
      wr(clock_select_pkg::SRC_DIV_ADDR, {1'b0, dv, 1'b0, sc});
      idle(2000);
      rd(clock_select_pkg::SRC_DIV_ADDR, {1'b1, dv, 1'b0, sc});
      measure(p);
      check(16'(p), 16'((2 * half[ix]) << dv));
    end
    // reserved source gives no clock, so a new divide cannot be applied
    wr(clock_select_pkg::SRC_DIV_ADDR, 8'h02);
    idle(50);
    lvl = sysclk_out;
    ch  = 0;
    for (int t = 0; t < 40; t++) begin
      @(negedge core_clk);
      if (sysclk_out !== lvl) ch++;
    end
    check(16'(ch), 16'h0000);
    wr(clock_select_pkg::SRC_DIV_ADDR, 8'h52);
    idle(100);
    rd(clock_select_pkg::SRC_DIV_ADDR, 8'h52);
    wr(clock_select_pkg::SRC_DIV_ADDR, 8'h04);
    idle(2000);
    rd(clock_select_pkg::SRC_DIV_ADDR, 8'h84);
    idle(3);
    report_and_stop();
  end
endmodule : system_clock_select_divide_tb_top
